// *** rtl/urfe_pkg.sv ***
package urfe_pkg;
	localparam logic [7:0] URFE_OFF_FEATURE = 8'h00;
	localparam logic [7:0] URFE_OFF_ENHANCED = 8'h04;
	localparam logic [7:0] URFE_OFF_MODEM = 8'h08;
	localparam logic [7:0] URFE_OFF_INT_EN = 8'h0C;
	localparam logic [7:0] URFE_OFF_FIFO = 8'h10;
	localparam logic [7:0] URFE_OFF_INT_STAT = 8'h14;
	localparam logic [7:0] URFE_OFF_MODEM_STAT = 8'h18;
	localparam logic [7:0] URFE_OFF_STOP_CHAR = 8'h1C;
	localparam logic [7:0] URFE_OFF_RX_TRIG = 8'h20;
	localparam logic [7:0] URFE_OFF_STATUS = 8'h24;
	localparam logic [7:0] URFE_RESET_BYTE = 8'h00;
	localparam int URFE_FC_RS485 = 5;
	localparam int URFE_FC_IR_INV = 4;
	localparam int URFE_EF_AUTO_CTS = 7;
	localparam int URFE_EF_AUTO_RTS = 6;
	localparam int URFE_EF_SPECIAL = 5;
	localparam int URFE_EF_ENH = 4;
	localparam int URFE_MC_SEL = 2;
	localparam int URFE_MC_RTS = 1;
	localparam int URFE_MC_DTR = 0;
	localparam int URFE_IS_SPECIAL = 4;
	localparam int URFE_IS_XOFF = 1;
	localparam logic [7:0] URFE_MASK_IER = 8'hE0;
	localparam logic [7:0] URFE_MASK_ISR = 8'h30;
	localparam logic [7:0] URFE_MASK_FCR = 8'h30;
	localparam logic [7:0] URFE_MASK_MCR = 8'hE0;
	localparam logic [7:0] URFE_MASK_MSR = 8'hFF;
	localparam logic [1:0] URFE_TABLE_D = 2'h3;
	localparam logic [1:0] URFE_DUAL_TX = 2'h3;
	localparam logic [9:0] URFE_NEXT_STEP = 10'h004;
	typedef enum logic [1:0]
	{
		URFE_DIR_RX = 2'b00,
		URFE_DIR_TX = 2'b01,
		URFE_DIR_TURN = 2'b10
	} urfe_dir_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} urfe_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} urfe_apb_rsp_t;
	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] enhanced_feature_control;
		logic [7:0] modem_control_reg;
		logic [7:0] interrupt_enable_reg;
		logic [7:0] fifo_control_reg;
		logic isr_hi;
		logic [7:0] modem_status_reg;
		logic [7:0] stop_char;
		logic [7:0] rx_trig;
		urfe_dir_t dir;
		logic [3:0] turn_cnt;
		logic flow_hold;
		logic special;
		logic xoff;
		logic tx_int;
		logic tx_halt;
		logic rx_trig_int;
		logic rx_store;
		logic rts_n;
		logic dtr_n;
		logic rx_ir_data;
		logic dual_tx;
		urfe_apb_rsp_t rsp;
	} urfe_state_t;
endpackage

// *** rtl/urfe_ctrl.sv ***
// Notes on behaviour
// - Direction drives RTS or DTR, picked by the modem control select bit.
// - Half-duplex direction control overrides automatic RTS/DTR flow control.
// - Direction off: transmit interrupt when the holding register empties.
// - Direction goes low after the last stop bit leaves the shift register.
// - Loading a byte raises direction before the start bit.
// - Direction on: transmit interrupt follows shift register empty.
// - Flow characters sent from an empty FIFO leave direction unchanged.
// - Infrared polarity bit: 0 passes receive input, 1 inverts it.
// - Hysteresis select applies only when trigger table D is selected.
// - Hysteresis resets to zero, meaning the next trigger level.
// - Hysteresis code maps to 0 to 52 characters per fixed table.
// - Low enhanced bits pick single or dual character flow control.
// - Auto CTS/DSR halts transmit while the chosen input is high.
// - Auto RTS/DTR: trigger interrupt, output high above, low below.
// - Without hardware flow control the pin follows its modem bit.
// - Special detect: match second stop char, store it, set status.
// - Comparing second pair: matched char dropped, two flags set.
// - Enhanced enable bit gates writes to the enhanced fields.
// - Reset clears all gated enhanced bits to zero.
// - Direction fall waits a programmed 0 to 15 bit times.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module urfe_ctrl
(
	input wire logic clk,
	input wire logic rst,
	input wire urfe_pkg::urfe_apb_req_t apb_req,
	output urfe_pkg::urfe_apb_rsp_t apb_rsp,
	input wire logic tx_load,
	input wire logic tx_fifo_empty,
	input wire logic tsr_empty,
	input wire logic tx_stop_done,
	input wire logic bit_tick,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char,
	input wire logic [8:0] rx_level,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic rx_ir_in,
	output logic rts_n,
	output logic dtr_n,
	output logic tx_halt,
	output logic tx_int,
	output logic rx_trig_int,
	output logic rx_store,
	output logic special_int,
	output logic xoff_int,
	output logic rx_ir_data,
	output logic dual_tx
);

	urfe_pkg::urfe_state_t cur;
	urfe_pkg::urfe_state_t next_state;
	logic rs485;
	logic auto_flow;
	logic sel_dtr;
	logic wr;
	logic rd;
	logic setup;
	logic [7:0] wdata;
	logic [9:0] hyst;
	logic [9:0] upper;
	logic [9:0] lower;
	logic [9:0] level;
	logic match;
	logic xoff_hit;
	logic special_hit;
	logic stat_rd;
	logic gp_sel_n;
	logic ctl_n;

	// Merges a write into a register whose enhanced bits may be locked.
	function automatic logic [7:0] gate_wr(input logic [7:0] old,
		input logic [7:0] val, input logic [7:0] mask, input logic en);
		gate_wr = (val & ~mask) | ((en ? val : old) & mask);
	endfunction

	// Translates the hysteresis select code into a character count.
	function automatic logic [9:0] hyst_chars(input logic [3:0] code);
		unique case (code)
			4'h0: hyst_chars = 10'h000;
			4'h1: hyst_chars = 10'h004;
			4'h2: hyst_chars = 10'h006;
			4'h3: hyst_chars = 10'h008;
			4'h4: hyst_chars = 10'h008;
			4'h5: hyst_chars = 10'h010;
			4'h6: hyst_chars = 10'h018;
			4'h7: hyst_chars = 10'h020;
			4'h8: hyst_chars = 10'h028;
			4'h9: hyst_chars = 10'h02C;
			4'hA: hyst_chars = 10'h030;
			4'hB: hyst_chars = 10'h034;
			4'hC: hyst_chars = 10'h00C;
			4'hD: hyst_chars = 10'h014;
			4'hE: hyst_chars = 10'h01C;
			4'hF: hyst_chars = 10'h024;
		endcase
	endfunction

	// Builds the read value for a register offset.
	function automatic logic [7:0] read_reg(input urfe_pkg::urfe_state_t s,
		input logic [7:0] addr);
		unique case (addr)
			urfe_pkg::URFE_OFF_FEATURE: read_reg = s.feature;
			urfe_pkg::URFE_OFF_ENHANCED: read_reg = s.enhanced_feature_control;
			urfe_pkg::URFE_OFF_MODEM: read_reg = s.modem_control_reg;
			urfe_pkg::URFE_OFF_INT_EN: read_reg = s.interrupt_enable_reg;
			urfe_pkg::URFE_OFF_FIFO: read_reg = s.fifo_control_reg;
			urfe_pkg::URFE_OFF_INT_STAT: read_reg = {2'b00, s.isr_hi, s.special,
				2'b00, s.xoff, 1'b0};
			urfe_pkg::URFE_OFF_MODEM_STAT: read_reg = s.modem_status_reg;
			urfe_pkg::URFE_OFF_STOP_CHAR: read_reg = s.stop_char;
			urfe_pkg::URFE_OFF_RX_TRIG: read_reg = s.rx_trig;
			urfe_pkg::URFE_OFF_STATUS: read_reg = {2'b00, s.rx_trig_int,
				s.tx_int, s.tx_halt, s.flow_hold, s.dir == urfe_pkg::URFE_DIR_TURN,
				s.dir == urfe_pkg::URFE_DIR_TX};
			default: read_reg = 8'h00;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = addr <= urfe_pkg::URFE_OFF_STATUS && addr[1:0] == 2'b00;
	endfunction

	assign setup = apb_req.psel & ~apb_req.penable;
	assign wr = apb_req.psel & apb_req.penable & cur.rsp.pready
		& apb_req.pwrite;
	assign rd = apb_req.psel & apb_req.penable & cur.rsp.pready
		& ~apb_req.pwrite;
	assign wdata = apb_req.pwdata[7:0];
	assign stat_rd = rd && apb_req.paddr == urfe_pkg::URFE_OFF_INT_STAT;

	assign rs485 = cur.feature[urfe_pkg::URFE_FC_RS485];
	assign auto_flow = cur.enhanced_feature_control[urfe_pkg::URFE_EF_AUTO_RTS] & ~rs485;
	assign sel_dtr = cur.modem_control_reg[urfe_pkg::URFE_MC_SEL];

	// Table D with a nonzero code uses the hysteresis, else the next level.
	assign hyst = (cur.feature[7:6] == urfe_pkg::URFE_TABLE_D
		&& cur.feature[3:0] != 4'h0) ? hyst_chars(cur.feature[3:0])
		: urfe_pkg::URFE_NEXT_STEP;
	assign level = {1'b0, rx_level};
	assign upper = {2'b00, cur.rx_trig} + hyst;
	assign lower = ({2'b00, cur.rx_trig} > hyst)
		? {2'b00, cur.rx_trig} - hyst : 10'h000;

	assign match = rx_char_valid && rx_char == cur.stop_char;
	assign special_hit = match & cur.enhanced_feature_control[urfe_pkg::URFE_EF_SPECIAL];
	assign xoff_hit = match & cur.enhanced_feature_control[0];

	assign gp_sel_n = sel_dtr ? ~cur.modem_control_reg[urfe_pkg::URFE_MC_DTR]
		: ~cur.modem_control_reg[urfe_pkg::URFE_MC_RTS];

	always_comb
	begin
		next_state = cur;
		next_state.rsp.pready = setup;
		if (setup)
		begin
			next_state.rsp.prdata = {24'h00_0000,
				read_reg(cur, apb_req.paddr)};
			next_state.rsp.pslverr = ~mapped(apb_req.paddr);
		end
		if (wr)
		begin
			unique case (apb_req.paddr)
				urfe_pkg::URFE_OFF_FEATURE: next_state.feature = wdata;
				urfe_pkg::URFE_OFF_ENHANCED: next_state.enhanced_feature_control = wdata;
				urfe_pkg::URFE_OFF_MODEM: next_state.modem_control_reg = gate_wr(cur.modem_control_reg,
					wdata, urfe_pkg::URFE_MASK_MCR,
					cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH]);
				urfe_pkg::URFE_OFF_INT_EN: next_state.interrupt_enable_reg = gate_wr(cur.interrupt_enable_reg,
					wdata, urfe_pkg::URFE_MASK_IER,
					cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH]);
				urfe_pkg::URFE_OFF_FIFO: next_state.fifo_control_reg = gate_wr(cur.fifo_control_reg,
					wdata, urfe_pkg::URFE_MASK_FCR,
					cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH]);
				urfe_pkg::URFE_OFF_INT_STAT:
				begin
					if (cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH])
					begin
						next_state.isr_hi = wdata[5];
						if (!wdata[urfe_pkg::URFE_IS_SPECIAL])
						begin
							next_state.special = 1'b0;
						end
					end
				end
				urfe_pkg::URFE_OFF_MODEM_STAT: next_state.modem_status_reg = gate_wr(cur.modem_status_reg,
					wdata, urfe_pkg::URFE_MASK_MSR,
					cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH]);
				urfe_pkg::URFE_OFF_STOP_CHAR: next_state.stop_char = wdata;
				urfe_pkg::URFE_OFF_RX_TRIG: next_state.rx_trig = wdata;
				default:
				begin
				end
			endcase
		end
		// Reading the status clears its sticky flags; a new event wins.
		if (stat_rd)
		begin
			next_state.special = cur.special
				& ~cur.rsp.prdata[urfe_pkg::URFE_IS_SPECIAL];
			next_state.xoff = cur.xoff & ~cur.rsp.prdata[urfe_pkg::URFE_IS_XOFF];
		end
		if (special_hit)
		begin
			next_state.special = 1'b1;
		end
		if (xoff_hit)
		begin
			next_state.xoff = 1'b1;
		end
		next_state.rx_store = rx_char_valid & ~xoff_hit;

		// Only a loaded byte raises direction, so flow characters sent
		// from an empty FIFO never move it.
		unique case (cur.dir)
			urfe_pkg::URFE_DIR_RX:
			begin
				if (rs485 && tx_load)
				begin
					next_state.dir = urfe_pkg::URFE_DIR_TX;
				end
			end
			urfe_pkg::URFE_DIR_TX:
			begin
				if (!rs485)
				begin
					next_state.dir = urfe_pkg::URFE_DIR_RX;
				end
				else if (tx_stop_done && tx_fifo_empty && !tx_load)
				begin
					if (cur.modem_status_reg[7:4] == 4'h0)
					begin
						next_state.dir = urfe_pkg::URFE_DIR_RX;
					end
					else
					begin
						next_state.dir = urfe_pkg::URFE_DIR_TURN;
						next_state.turn_cnt = cur.modem_status_reg[7:4];
					end
				end
			end
			urfe_pkg::URFE_DIR_TURN:
			begin
				if (!rs485)
				begin
					next_state.dir = urfe_pkg::URFE_DIR_RX;
				end
				else if (tx_load)
				begin
					next_state.dir = urfe_pkg::URFE_DIR_TX;
				end
				else if (bit_tick)
				begin
					if (cur.turn_cnt == 4'h1)
					begin
						next_state.dir = urfe_pkg::URFE_DIR_RX;
					end
					next_state.turn_cnt = cur.turn_cnt - 4'h1;
				end
			end
			default: next_state.dir = urfe_pkg::URFE_DIR_RX;
		endcase

		// Flow hold raises the pin at the upper level, drops it below lower.
		if (!auto_flow)
		begin
			next_state.flow_hold = 1'b0;
		end
		else if (level >= upper)
		begin
			next_state.flow_hold = 1'b1;
		end
		else if (level < lower)
		begin
			next_state.flow_hold = 1'b0;
		end

		if (rs485)
		begin
			ctl_n = next_state.dir != urfe_pkg::URFE_DIR_RX;
		end
		else if (auto_flow)
		begin
			ctl_n = gp_sel_n | next_state.flow_hold;
		end
		else
		begin
			ctl_n = gp_sel_n;
		end
		next_state.rts_n = sel_dtr ? ~cur.modem_control_reg[urfe_pkg::URFE_MC_RTS]
			: ctl_n;
		next_state.dtr_n = sel_dtr ? ctl_n
			: ~cur.modem_control_reg[urfe_pkg::URFE_MC_DTR];

		next_state.tx_int = rs485 ? (tx_fifo_empty & tsr_empty)
			: tx_fifo_empty;
		next_state.tx_halt = cur.enhanced_feature_control[urfe_pkg::URFE_EF_AUTO_CTS]
			& (sel_dtr ? dsr_n : cts_n);
		next_state.rx_trig_int = cur.rx_trig != 8'h00
			&& level >= {2'b00, cur.rx_trig};
		next_state.rx_ir_data = rx_ir_in
			^ cur.feature[urfe_pkg::URFE_FC_IR_INV];
		next_state.dual_tx = cur.enhanced_feature_control[3:2] == urfe_pkg::URFE_DUAL_TX;

		if (rst)
		begin
			next_state = '0;
			next_state.rts_n = 1'b1;
			next_state.dtr_n = 1'b1;
			next_state.dir = urfe_pkg::URFE_DIR_RX;
		end
	end

	always_ff @(posedge clk)
	begin
		cur <= next_state;
	end

	assign apb_rsp = cur.rsp;
	assign rts_n = cur.rts_n;
	assign dtr_n = cur.dtr_n;
	assign tx_halt = cur.tx_halt;
	assign tx_int = cur.tx_int;
	assign rx_trig_int = cur.rx_trig_int;
	assign rx_store = cur.rx_store;
	assign special_int = cur.special;
	assign xoff_int = cur.xoff;
	assign rx_ir_data = cur.rx_ir_data;
	assign dual_tx = cur.dual_tx;

	a_dir_raise: assert property (@(posedge clk) disable iff (rst)
		(rs485 && cur.dir == urfe_pkg::URFE_DIR_RX && tx_load && !sel_dtr)
		|=> rts_n)
		else $error("direction did not rise on load");

	a_dir_fall_now: assert property (@(posedge clk) disable iff (rst)
		(rs485 && cur.dir == urfe_pkg::URFE_DIR_TX && tx_stop_done
		&& tx_fifo_empty && !tx_load && cur.modem_status_reg[7:4] == 4'h0 && !sel_dtr)
		|=> !rts_n)
		else $error("direction did not fall after last stop bit");

	a_turn_wait: assert property (@(posedge clk) disable iff (rst)
		(rs485 && cur.dir == urfe_pkg::URFE_DIR_TURN && !tx_load && !bit_tick)
		|=> cur.dir == urfe_pkg::URFE_DIR_TURN && $stable(cur.turn_cnt))
		else $error("turnaround ended without a bit time");

	a_tx_int_tsr: assert property (@(posedge clk) disable iff (rst)
		(!rst && rs485) |=> tx_int == $past(tx_fifo_empty & tsr_empty))
		else $error("transmit interrupt not from shift register");

	a_tx_int_thr: assert property (@(posedge clk) disable iff (rst)
		(!rst && !rs485) |=> tx_int == $past(tx_fifo_empty))
		else $error("transmit interrupt not from holding register");

	a_cts_halt: assert property (@(posedge clk) disable iff (rst)
		(!rst && cur.enhanced_feature_control[urfe_pkg::URFE_EF_AUTO_CTS] && !sel_dtr)
		|=> tx_halt == $past(cts_n))
		else $error("transmit halt does not follow clear to send");

	a_xoff_drop: assert property (@(posedge clk) disable iff (rst)
		(match && cur.enhanced_feature_control[1:0] == 2'b01 && cur.enhanced_feature_control[urfe_pkg::URFE_EF_SPECIAL])
		|=> !rx_store && xoff_int && special_int)
		else $error("second stop char not handled");

	a_special_keep: assert property (@(posedge clk) disable iff (rst)
		(special_hit && cur.enhanced_feature_control[1:0] == 2'b10) |=> rx_store && special_int)
		else $error("special character not stored or flagged");

	a_enh_lock: assert property (@(posedge clk) disable iff (rst)
		(wr && apb_req.paddr == urfe_pkg::URFE_OFF_MODEM
		&& !cur.enhanced_feature_control[urfe_pkg::URFE_EF_ENH]) |=> $stable(cur.modem_control_reg[7:5]))
		else $error("locked enhanced bits changed");

	a_rs485_prio: assert property (@(posedge clk) disable iff (rst)
		(rs485 && $past(rs485) && !sel_dtr && !$past(sel_dtr))
		|-> rts_n == ($past(next_state.dir) != urfe_pkg::URFE_DIR_RX))
		else $error("direction control lost priority");

endmodule

// *** tb/urfe_modem_model.sv ***
`timescale 1ns/1ns
module urfe_modem_model
(
	input wire logic clk,
	input wire logic [1:0] stop_req,
	input wire logic ir_bit,
	output logic cts_n = 1'h0,
	output logic dsr_n = 1'h0,
	output logic rx_ir_in = 1'h0
);
	// The remote end pulls its clear or ready line high to hold us off.
	always @(posedge clk)
	begin
		cts_n <= stop_req[0];
		dsr_n <= stop_req[1];
		rx_ir_in <= ir_bit;
	end
endmodule

// *** tb/uart_rs485_flow_enhanced_ctrl_bench.sv ***
`timescale 1ns/1ns
module uart_rs485_flow_enhanced_ctrl_bench;
	logic clk = 1'h0;
	logic rst = 1'h1;
	urfe_pkg::urfe_apb_req_t apb_req = '0;
	urfe_pkg::urfe_apb_rsp_t apb_rsp;
	logic [3:0] pls = '0;
	logic tx_fifo_empty = 1'h1;
	logic tsr_empty = 1'h1;
	logic [7:0] rx_char = '0;
	logic [8:0] rx_level = '0;
	logic [1:0] stop_req = '0;
	logic ir_bit = 1'h0;
	logic cts_n, dsr_n, rx_ir_in, rts_n, dtr_n, tx_halt, tx_int;
	logic rx_trig_int, rx_store, special_int, xoff_int, rx_ir_data;
	logic dual_tx, last_err;
	logic [31:0] rdata;
	int num_errors = 0;
	int n_checks = 0;

	always #2 clk = ~clk;

	urfe_ctrl u_urfe_ctrl
	(
		.clk, .rst, .apb_req, .apb_rsp, .tx_load(pls[0]),
		.tx_fifo_empty, .tsr_empty, .tx_stop_done(pls[1]),
		.bit_tick(pls[2]), .rx_char_valid(pls[3]), .rx_char,
		.rx_level, .cts_n, .dsr_n, .rx_ir_in, .rts_n, .dtr_n,
		.tx_halt, .tx_int, .rx_trig_int, .rx_store, .special_int,
		.xoff_int, .rx_ir_data, .dual_tx
	);

	urfe_modem_model u_urfe_modem_model
	(
		.clk, .stop_req, .ir_bit, .cts_n, .dsr_n, .rx_ir_in
	);

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		apb_req <= '{1'h1, 1'h0, w, a, d};
		@(posedge clk);
		apb_req.penable <= 1'h1;
		do
		begin
			@(posedge clk);
		end
		while (apb_rsp.pready !== 1'h1);
		rdata = apb_rsp.prdata;
		last_err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, {24'h00_0000, d});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		apb(1'h0, a, '0);
		chk(rdata, {24'h00_0000, e});
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		pls <= m;
		@(posedge clk);
		pls <= '0;
		#1;
	endtask

	task automatic restart;
		@(posedge clk);
		rst <= 1'h1;
		tx_fifo_empty <= 1'h1;
		tsr_empty <= 1'h1;
		rx_level <= '0;
		stop_req <= '0;
		@(posedge clk);
		rst <= 1'h0;
	endtask

	task automatic fl(input int l, input logic e);
		@(posedge clk);
		rx_level <= 9'(l);
		cyc(3);
		chk(32'(rts_n), 32'(e));
	endtask

	task automatic hs(input logic [1:0] s, input logic e);
		@(posedge clk);
		stop_req <= s;
		cyc(5);
		chk(32'(tx_halt), 32'(e));
	endtask

	task automatic rxc(input logic [7:0] ch, input logic e);
		@(posedge clk);
		rx_char <= ch;
		pulse(4'h8);
		chk(32'(rx_store), 32'(e));
		cyc(1);
		chk(32'(rx_store), 32'h0);
	endtask

	task automatic t_regs;
		chk(32'({rts_n, dtr_n}), 32'h3);
		for (int a = 0; a < 36; a += 4)
			rdc(8'(a), 8'h00);
		rdc(urfe_pkg::URFE_OFF_STATUS, 8'h10);
		rdc(8'h28, 8'h00);
		chk(32'(last_err), 32'h1);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'hFF);
		rdc(urfe_pkg::URFE_OFF_MODEM, 8'h1F);
		wr(urfe_pkg::URFE_OFF_MODEM_STAT, 8'hF0);
		rdc(urfe_pkg::URFE_OFF_MODEM_STAT, 8'h00);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h10);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'hE0);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h00);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'h00);
		rdc(urfe_pkg::URFE_OFF_MODEM, 8'hE0);
		$display("t_regs done");
	endtask

	task automatic t_dir;
		restart();
		@(posedge clk);
		tsr_empty <= 1'h0;
		cyc(3);
		chk(32'(tx_int), 32'h1);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h50);
		wr(urfe_pkg::URFE_OFF_MODEM_STAT, 8'h20);
		wr(urfe_pkg::URFE_OFF_RX_TRIG, 8'h04);
		wr(urfe_pkg::URFE_OFF_FEATURE, 8'h20);
		@(posedge clk);
		rx_level <= 9'h1FF;
		cyc(4);
		chk(32'({tx_int, rts_n}), 32'h0);
		@(posedge clk);
		tx_fifo_empty <= 1'h0;
		pulse(4'h1);
		chk(32'(rts_n), 32'h1);
		@(posedge clk);
		tx_fifo_empty <= 1'h1;
		tsr_empty <= 1'h1;
		pulse(4'h2);
		pulse(4'h4);
		cyc(3);
		chk(32'(rts_n), 32'h1);
		pulse(4'h4);
		cyc(2);
		chk(32'({rts_n, tx_int}), 32'h1);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h58);
		fl(0, 1'h0);
		fl(511, 1'h0);
		wr(urfe_pkg::URFE_OFF_MODEM_STAT, 8'h00);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'h04);
		pulse(4'h1);
		chk(32'(dtr_n), 32'h1);
		pulse(4'h2);
		cyc(1);
		chk(32'(dtr_n), 32'h0);
		$display("t_dir done");
	endtask

	task automatic t_ir;
		restart();
		@(posedge clk);
		ir_bit <= 1'h1;
		cyc(4);
		chk(32'(rx_ir_data), 32'h1);
		wr(urfe_pkg::URFE_OFF_FEATURE, 8'h10);
		cyc(2);
		chk(32'(rx_ir_data), 32'h0);
		$display("t_ir done");
	endtask

	task automatic t_cts;
		restart();
		hs(2'h1, 1'h0);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h80);
		hs(2'h1, 1'h1);
		hs(2'h2, 1'h0);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'h04);
		hs(2'h2, 1'h1);
		hs(2'h1, 1'h0);
		$display("t_cts done");
	endtask

	task automatic t_flow;
		int hy[16] = '{4, 4, 6, 8, 8, 16, 24, 32,
			40, 44, 48, 52, 12, 20, 28, 36};
		restart();
		wr(urfe_pkg::URFE_OFF_RX_TRIG, 8'h64);
		wr(urfe_pkg::URFE_OFF_MODEM, 8'h02);
		cyc(2);
		chk(32'(rts_n), 32'h0);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h40);
		for (int c = 0; c < 16; c++)
		begin
			wr(urfe_pkg::URFE_OFF_FEATURE, {4'hC, 4'(c)});
			fl(99 + hy[c], 1'h0);
			chk(32'(rx_trig_int), 32'h1);
			fl(100 + hy[c], 1'h1);
			fl(100 - hy[c], 1'h1);
			fl(99 - hy[c], 1'h0);
		end
		wr(urfe_pkg::URFE_OFF_FEATURE, 8'h08);
		fl(104, 1'h1);
		$display("t_flow done");
	endtask

	task automatic t_spec;
		restart();
		wr(urfe_pkg::URFE_OFF_STOP_CHAR, 8'h13);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h30);
		rxc(8'h41, 1'h1);
		chk(32'(special_int), 32'h0);
		rxc(8'h13, 1'h1);
		rdc(urfe_pkg::URFE_OFF_INT_STAT, 8'h10);
		cyc(2);
		chk(32'(special_int), 32'h0);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h31);
		rxc(8'h13, 1'h0);
		chk(32'({special_int, xoff_int}), 32'h3);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h30);
		rdc(urfe_pkg::URFE_OFF_INT_STAT, 8'h12);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h32);
		rxc(8'h13, 1'h1);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h30);
		wr(urfe_pkg::URFE_OFF_ENHANCED, 8'h0C);
		cyc(2);
		chk(32'(dual_tx), 32'h1);
		$display("t_spec done");
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		cyc(1);
		t_regs();
		t_dir();
		t_ir();
		t_cts();
		t_flow();
		t_spec();
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
